// >>> logic/programmable_io_lines.v
// Thirty-two programmable I/O lines with mode, direction and level registers
//
// Overview of operation
// R1: Each of 32 shared lines can be software input or output instead of peripheral.
// R2: Two 16-bit mode/direction register pairs; low pair lines 0-15, high pair 16-31.
// R3: Mode/direction 00 normal, 01 pulled input, 10 output, 11 unpulled input.
// R4: Pull direction is fixed per line; software cannot choose it.
// R5: Reset: pulled-up inputs, lines 1 and 10 pulled down, lines 4-8 normal.
// R6: Normal setting routes the line to its dedicated peripheral.
// R7: Input levels read back as two 16-bit status words, low and high bank.
// R8: Written levels drive a line only while that line is set to output.
// R9: Board must not pull the two strap lines low during reset.
// R10: Software should leave lines of fitted on-board parts untouched.
// R11: Low-bank bit n is line n; high-bank bit n is line n plus sixteen.
`timescale 1ns/1ps
`default_nettype none
`include "io_lines_defines.vh"

module programmable_io_lines #(
  parameter LINES = 32
) (
  // Clock and reset
  input  wire                clock,
  input  wire                nrst,
  // I/O space register port
  input  wire                io_sel,
  input  wire                io_wr,
  input  wire                io_rd,
  input  wire [15:0]         io_addr,
  input  wire [1:0]          io_be,
  input  wire [15:0]         io_wdata,
  output reg  [15:0]         io_rdata_ff,
  output reg                 io_ack_ff,
  // Pins
  input  wire [LINES-1:0]    pin_in,
  output wire [LINES-1:0]    pin_out,
  output wire [LINES-1:0]    pin_oe,
  output wire [LINES-1:0]    pull_up_en,
  output wire [LINES-1:0]    pull_down_en,
  // Shared peripheral functions
  input  wire [LINES-1:0]    periph_out,
  input  wire [LINES-1:0]    periph_oe,
  output wire [LINES-1:0]    periph_in
);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg  [15:0] low_bank_mode_ff;
  reg  [15:0] low_bank_direction_ff;
  reg  [15:0] low_bank_level_ff;
  reg  [15:0] high_bank_mode_ff;
  reg  [15:0] high_bank_direction_ff;
  reg  [15:0] high_bank_level_ff;

  reg  [15:0] nxt_low_bank_mode;
  reg  [15:0] nxt_low_bank_direction;
  reg  [15:0] nxt_low_bank_level;
  reg  [15:0] nxt_high_bank_mode;
  reg  [15:0] nxt_high_bank_direction;
  reg  [15:0] nxt_high_bank_level;
  reg  [15:0] nxt_io_rdata;

  wire [15:0] lane_mask;
  wire        wr_req;
  wire        rd_req;
  wire        hit_low_mode;
  wire        hit_low_dir;
  wire        hit_low_level;
  wire        hit_high_mode;
  wire        hit_high_dir;
  wire        hit_high_level;

  wire [LINES-1:0] line_mode;
  wire [LINES-1:0] line_dir;
  wire [LINES-1:0] line_level;
  wire [LINES-1:0] line_status;

  // Per-line pull sense and reset pull, one bit each so cell parameters stay 1-bit wide
  localparam [31:0] PULL_DOWN_BITS = `PULL_DOWN_MASK;
  localparam [31:0] RST_PULL_BITS  = {`HIGH_BANK_DIRECTION_RST, `LOW_BANK_DIRECTION_RST};

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  assign wr_req = io_sel & io_wr;
  assign rd_req = io_sel & io_rd & ~io_wr;

  assign hit_low_mode   = (io_addr == `LOW_BANK_MODE_ADDR);       // [R2]
  assign hit_low_dir    = (io_addr == `LOW_BANK_DIRECTION_ADDR);  // [R2]
  assign hit_low_level  = (io_addr == `LOW_BANK_LEVEL_ADDR);
  assign hit_high_mode  = (io_addr == `HIGH_BANK_MODE_ADDR);      // [R2]
  assign hit_high_dir   = (io_addr == `HIGH_BANK_DIRECTION_ADDR); // [R2]
  assign hit_high_level = (io_addr == `HIGH_BANK_LEVEL_ADDR);

  // Byte enables allow an 8-bit processor bus to update one half at a time
  assign lane_mask = {{8{io_be[1]}}, {8{io_be[0]}}};

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @* begin
    nxt_low_bank_mode       = low_bank_mode_ff;
    nxt_low_bank_direction  = low_bank_direction_ff;
    nxt_low_bank_level      = low_bank_level_ff;
    nxt_high_bank_mode      = high_bank_mode_ff;
    nxt_high_bank_direction = high_bank_direction_ff;
    nxt_high_bank_level     = high_bank_level_ff;
    if (wr_req) begin
      if (hit_low_mode) begin
        nxt_low_bank_mode = (low_bank_mode_ff & ~lane_mask) | (io_wdata & lane_mask);
      end
      if (hit_low_dir) begin
        nxt_low_bank_direction = (low_bank_direction_ff & ~lane_mask)
                               | (io_wdata & lane_mask);
      end
      if (hit_low_level) begin
        // Stored for every line, but only output lines ever show it
        nxt_low_bank_level = (low_bank_level_ff & ~lane_mask)
                           | (io_wdata & lane_mask);                // [R8]
      end
      if (hit_high_mode) begin
        nxt_high_bank_mode = (high_bank_mode_ff & ~lane_mask) | (io_wdata & lane_mask);
      end
      if (hit_high_dir) begin
        nxt_high_bank_direction = (high_bank_direction_ff & ~lane_mask)
                                | (io_wdata & lane_mask);
      end
      if (hit_high_level) begin
        nxt_high_bank_level = (high_bank_level_ff & ~lane_mask)
                            | (io_wdata & lane_mask);               // [R8]
      end
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      low_bank_mode_ff       <= `LOW_BANK_MODE_RST;                 // [R5]
      low_bank_direction_ff  <= `LOW_BANK_DIRECTION_RST;            // [R5]
      low_bank_level_ff      <= `LEVEL_RST;
      high_bank_mode_ff      <= `HIGH_BANK_MODE_RST;                // [R5]
      high_bank_direction_ff <= `HIGH_BANK_DIRECTION_RST;           // [R5]
      high_bank_level_ff     <= `LEVEL_RST;
    end else begin
      low_bank_mode_ff       <= nxt_low_bank_mode;
      low_bank_direction_ff  <= nxt_low_bank_direction;
      low_bank_level_ff      <= nxt_low_bank_level;
      high_bank_mode_ff      <= nxt_high_bank_mode;
      high_bank_direction_ff <= nxt_high_bank_direction;
      high_bank_level_ff     <= nxt_high_bank_level;
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  // Level offsets read the sampled pin state, not the written latch, so
  // software sees inputs; output lines echo their driven level.
  always @* begin
    nxt_io_rdata = `READ_IDLE;
    if (rd_req) begin
      if (hit_low_mode) begin
        nxt_io_rdata = low_bank_mode_ff;
      end else if (hit_low_dir) begin
        nxt_io_rdata = low_bank_direction_ff;
      end else if (hit_low_level) begin
        nxt_io_rdata = line_status[`BANK_WIDTH-1:0];                // [R7]
      end else if (hit_high_mode) begin
        nxt_io_rdata = high_bank_mode_ff;
      end else if (hit_high_dir) begin
        nxt_io_rdata = high_bank_direction_ff;
      end else if (hit_high_level) begin
        nxt_io_rdata = line_status[LINES-1:`BANK_WIDTH];            // [R7]
      end else begin
        nxt_io_rdata = `READ_IDLE;
      end
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      io_rdata_ff <= `READ_IDLE;
      io_ack_ff   <= 1'b0;
    end else begin
      io_rdata_ff <= nxt_io_rdata;
      io_ack_ff   <= wr_req | rd_req;
    end
  end

  // --------------------------------------------------------------------------
  // Bank to line mapping
  // --------------------------------------------------------------------------
  assign line_mode  = {high_bank_mode_ff, low_bank_mode_ff};         // [R11]
  assign line_dir   = {high_bank_direction_ff, low_bank_direction_ff}; // [R11]
  assign line_level = {high_bank_level_ff, low_bank_level_ff};       // [R11]

  // --------------------------------------------------------------------------
  // Line cells
  // --------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < LINES; i = i + 1) begin : g_line
      io_line_cell #(
        .PULL_DOWN (PULL_DOWN_BITS[i]),                              // [R4]
        .RST_PULL  (RST_PULL_BITS[i])                                // [R5]
      ) u_cell (
        .clock        (clock),
        .nrst         (nrst),
        .mode_bit     (line_mode[i]),                                // [R1]
        .dir_bit      (line_dir[i]),
        .level_bit    (line_level[i]),
        .pin_in       (pin_in[i]),
        .periph_out   (periph_out[i]),
        .periph_oe    (periph_oe[i]),
        .pin_out_ff   (pin_out[i]),
        .pin_oe_ff    (pin_oe[i]),
        .pull_up_ff   (pull_up_en[i]),
        .pull_down_ff (pull_down_en[i]),
        .periph_in_ff (periph_in[i]),
        .status_ff    (line_status[i])
      );
    end
  endgenerate

endmodule // programmable_io_lines
`default_nettype wire

// >>> logic/io_lines_defines.vh
// Constants for the programmable I/O line block: offsets, reset values, decode codes
`ifndef IO_LINES_DEFINES_VH
`define IO_LINES_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets in I/O space
// ----------------------------------------------------------------------------
`define LOW_BANK_MODE_ADDR      16'hFF70
`define LOW_BANK_DIRECTION_ADDR 16'hFF72
`define LOW_BANK_LEVEL_ADDR     16'hFF74
`define HIGH_BANK_MODE_ADDR     16'hFF76
`define HIGH_BANK_DIRECTION_ADDR 16'hFF78
`define HIGH_BANK_LEVEL_ADDR    16'hFF7A

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LOW_BANK_MODE_RST       16'h0000
`define HIGH_BANK_MODE_RST      16'h0000
`define LOW_BANK_DIRECTION_RST  16'hFE0F
`define HIGH_BANK_DIRECTION_RST 16'hFFFF
`define LEVEL_RST               16'h0000

// Lines whose fixed pull resistor pulls down (timer one and timer zero outputs)
`define PULL_DOWN_MASK          32'h0000_0402

// ----------------------------------------------------------------------------
// Per-line setting codes, {mode, direction}
// ----------------------------------------------------------------------------
`define SET_NORMAL              2'h0
`define SET_IN_PULL             2'h1
`define SET_OUTPUT              2'h2
`define SET_IN_FLOAT            2'h3

`define BANK_WIDTH              16
`define READ_IDLE               16'h0000

`endif

// >>> logic/io_line_cell.v
// One programmable I/O line: setting decode, pin drive, pull control and sampling
`timescale 1ns/1ps
`default_nettype none
`include "io_lines_defines.vh"

module io_line_cell #(
  parameter PULL_DOWN = 1'b0,
  parameter RST_PULL  = 1'b1
) (
  // Clock and reset
  input  wire clock,
  input  wire nrst,
  // Settings from the register file
  input  wire mode_bit,
  input  wire dir_bit,
  input  wire level_bit,
  // Pin and shared peripheral
  input  wire pin_in,
  input  wire periph_out,
  input  wire periph_oe,
  output reg  pin_out_ff,
  output reg  pin_oe_ff,
  output reg  pull_up_ff,
  output reg  pull_down_ff,
  output reg  periph_in_ff,
  output reg  status_ff
);

  reg nxt_pin_out;
  reg nxt_pin_oe;
  reg nxt_pull;
  reg nxt_periph_in;
  reg nxt_status;

  // --------------------------------------------------------------------------
  // Setting decode
  // --------------------------------------------------------------------------
  always @* begin
    nxt_pin_out   = 1'b0;
    nxt_pin_oe    = 1'b0;
    nxt_pull      = 1'b0;
    nxt_periph_in = PULL_DOWN ? 1'b0 : 1'b1;
    nxt_status    = pin_in;                         // [R7]
    case ({mode_bit, dir_bit})                      // [R3]
      `SET_NORMAL: begin
        nxt_pin_out   = periph_out;                 // [R6]
        nxt_pin_oe    = periph_oe;                  // [R6]
        nxt_periph_in = pin_in;                     // [R6]
      end
      `SET_IN_PULL: begin
        nxt_pull = 1'b1;
      end
      `SET_OUTPUT: begin
        nxt_pin_out = level_bit;                    // [R8]
        nxt_pin_oe  = 1'b1;                         // [R8]
        nxt_status  = level_bit;
      end
      `SET_IN_FLOAT: begin
        nxt_pull = 1'b0;
      end
      default: begin
        nxt_pull = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Output flops; pull sense is fixed per line and never software visible
  // --------------------------------------------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_out_ff   <= 1'b0;
      pin_oe_ff    <= 1'b0;
      pull_up_ff   <= RST_PULL & ~PULL_DOWN;        // [R5]
      pull_down_ff <= RST_PULL & PULL_DOWN;         // [R5]
      periph_in_ff <= PULL_DOWN ? 1'b0 : 1'b1;
      status_ff    <= 1'b0;
    end else begin
      pin_out_ff   <= nxt_pin_out;
      pin_oe_ff    <= nxt_pin_oe;
      pull_up_ff   <= nxt_pull & ~PULL_DOWN;        // [R4]
      pull_down_ff <= nxt_pull & PULL_DOWN;         // [R4]
      periph_in_ff <= nxt_periph_in;
      status_ff    <= nxt_status;
    end
  end

endmodule // io_line_cell
`default_nettype wire

// >>> bench/board_model.sv
// Board-side model: resolves each line from block drive, external drive and pulls
`timescale 1ns/1ps
`default_nettype none
module board_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Block side of the lines
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pull_up_en,
  input  wire logic [31:0] pull_down_en,
  // External circuitry
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  output logic      [31:0] pin_in
);
  logic [31:0] float_ff;
  logic [31:0] ext_ok;
  // Straps never see a low board drive while reset is active
  assign ext_ok = nrst ? ext_en : ext_en & ~(~ext_val & 32'h2400_0000);
  // A floating line wanders every cycle so no one can lean on its last value
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      float_ff <= 32'h5555_AAAA;
    else
      float_ff <= ~float_ff;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_ok & ext_val)
                | (~pin_oe & ~ext_ok & (pull_up_en | (~pull_down_en & float_ff)));
endmodule // board_model
`default_nettype wire

// >>> bench/programmable_io_lines_properties.sv
// Port-level assertions for the programmable I/O line block
`timescale 1ns/1ps
`default_nettype none
`include "io_lines_defines.vh"
module programmable_io_lines_properties #(
  parameter LINES = 32
) (
  // Clock and reset
  input wire logic             clock,
  input wire logic             nrst,
  // Register port
  input wire logic             io_sel,
  input wire logic             io_wr,
  input wire logic             io_rd,
  input wire logic [15:0]      io_addr,
  input wire logic [15:0]      io_rdata_ff,
  input wire logic             io_ack_ff,
  // Pins and peripherals
  input wire logic [LINES-1:0] pin_out,
  input wire logic [LINES-1:0] pin_oe,
  input wire logic [LINES-1:0] pull_up_en,
  input wire logic [LINES-1:0] pull_down_en,
  input wire logic [LINES-1:0] periph_out,
  input wire logic [LINES-1:0] periph_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire mapped = io_addr[15:4] == 12'hFF7 && !io_addr[0] && io_addr[3:0] <= 4'hA;
  sequence s_access;
    io_sel && (io_rd || io_wr);
  endsequence
  sequence s_read_unmapped;
    io_sel && io_rd && !io_wr && !mapped;
  endsequence
  chk_ack_follows: assert property (s_access |=> io_ack_ff) else $error("no ack");
  chk_ack_cause: assert property (io_ack_ff |-> $past(io_sel && (io_rd || io_wr)))
    else $error("stray ack");
  chk_rdata_idle: assert property (!io_ack_ff |-> io_rdata_ff == 16'h0000)
    else $error("read data outside ack");
  chk_unmapped_zero: assert property (s_read_unmapped |=> io_rdata_ff == 16'h0000)
    else $error("unmapped read not zero");
  chk_pull_fixed: assert property (((pull_up_en & `PULL_DOWN_MASK)
    | (pull_down_en & ~`PULL_DOWN_MASK)) == 32'h0) else $error("pull sense wrong");
  chk_pull_drive_excl: assert property (((pull_up_en | pull_down_en) & pin_oe) == 32'h0)
    else $error("pull while driving");
  chk_reset_defaults: assert property ($rose(nrst) |-> pull_up_en == 32'hFFFF_FA0D
    && pull_down_en == 32'h0000_0402 && pin_oe == 32'h0) else $error("reset pins");
  chk_oe_cause: assert property ($past(nrst, 3) && pin_oe != $past(pin_oe) |->
    $past(io_sel && io_wr, 2) || $past(periph_oe) != $past(periph_oe, 2))
    else $error("drive enable changed alone");
  chk_out_cause: assert property ($past(nrst, 3) && pin_out != $past(pin_out) |->
    $past(io_sel && io_wr, 2) || $past(periph_out) != $past(periph_out, 2))
    else $error("level changed alone");
endmodule // programmable_io_lines_properties
bind programmable_io_lines programmable_io_lines_properties #(.LINES(LINES)) u_props (
  .clock(clock), .nrst(nrst), .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd),
  .io_addr(io_addr), .io_rdata_ff(io_rdata_ff), .io_ack_ff(io_ack_ff),
  .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en), .periph_out(periph_out), .periph_oe(periph_oe));
`default_nettype wire

// >>> bench/programmable_io_lines_tb.sv
// Self-checking bench for the programmable I/O line block
`timescale 1ns/1ps
`default_nettype none
module programmable_io_lines_tb;
  logic        clock, nrst, io_sel, io_wr, io_rd;
  logic [15:0] io_addr, io_wdata, rd, base;
  logic [1:0]  io_be;
  logic [31:0] periph_out, periph_oe, ext_en, ext_val;
  wire  [15:0] io_rdata_ff;
  wire         io_ack_ff;
  wire  [31:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, periph_in;
  int          miscompares, total_checks, i, k, b, c;
  logic [15:0] adr [4] = '{16'hFF70, 16'hFF72, 16'hFF76, 16'hFF78};
  logic [15:0] rst [4] = '{16'h0000, 16'hFE0F, 16'h0000, 16'hFFFF};
  programmable_io_lines #(.LINES(32)) DUT (.clock(clock), .nrst(nrst), .io_sel(io_sel),
    .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata),
    .io_rdata_ff(io_rdata_ff), .io_ack_ff(io_ack_ff), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in));
  board_model board (.clock(clock), .nrst(nrst), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle strobe; the ack is looked for on the cycle after the taking edge
  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
                     input logic [1:0] be);
    @(negedge clock);
    io_sel = 1'b1;
    io_wr = wr;
    io_rd = !wr;
    io_addr = a;
    io_wdata = d;
    io_be = be;
    @(negedge clock);
    io_sel = 1'b0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    for (k = 0; k < 3 && io_ack_ff !== 1'b1; k++) @(negedge clock);
    if (io_ack_ff !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
    rd = io_rdata_ff;
  endtask
  initial begin
    nrst = 1'b0;
    {io_sel, io_wr, io_rd, io_be} = 5'h00;
    io_addr = 16'h0000;
    io_wdata = 16'h0000;
    {periph_out, periph_oe, ext_en, ext_val} = 128'h0;
    miscompares = 0;
    total_checks = 0;
    repeat (6) @(posedge clock);
    @(negedge clock) nrst = 1'b1;
    check(pull_up_en, 32'hFFFF_FA0D);
    check(pull_down_en, 32'h0000_0402);
    for (i = 0; i < 4; i++) begin
      acc(1'b0, adr[i], 16'h0000, 2'h3);
      check(rd, rst[i]);
    end
    $display("reset defaults done");
    for (i = 0; i < 4; i++) begin
      acc(1'b1, adr[i], 16'h5A3C, 2'h3);
      acc(1'b1, adr[i], 16'hFFFF, 2'h1);
      acc(1'b0, adr[i], 16'h0000, 2'h3);
      check(rd, 16'h5AFF);
    end
    $display("register access done");
    periph_oe = 32'hFFFF_FFFF;
    ext_en = 32'hFFFF_FFFF;
    for (b = 0; b < 2; b++)
      for (c = 0; c < 4; c++) begin
        base = b ? 16'hFF76 : 16'hFF70;
        // Lines 13 and 29 are exercised: the whole-word writes also set every other line of the bank to normal
        acc(1'b1, base + 16'h0004, 16'h2000, 2'h3);
        acc(1'b1, base, {2'h0, c[1], 13'h0000}, 2'h3);
        acc(1'b1, base + 16'h0002, {2'h0, c[0], 13'h0000}, 2'h3);
        repeat (2) @(negedge clock);
        check(pin_oe[13 + 16 * b], !c[0]);
        if (!c[0]) check(pin_out[13 + 16 * b], c == 2);
        check(pull_up_en[13 + 16 * b], c == 1);
        check(periph_in[13 + 16 * b], c != 0);
        acc(1'b0, base + 16'h0004, 16'h0000, 2'h3);
        check(rd[13], c == 2);
      end
    $display("line settings done");
    acc(1'b1, 16'hFF70, 16'h0000, 2'h3);
    acc(1'b1, 16'hFF72, 16'h0400, 2'h3);
    repeat (2) @(negedge clock);
    check(pull_down_en[10], 1'b1);
    check(pull_up_en[10], 1'b0);
    acc(1'b1, 16'hFF7C, 16'hFFFF, 2'h3);
    acc(1'b0, 16'hFF7C, 16'h0000, 2'h3);
    check(rd, 16'h0000);
    acc(1'b0, 16'hFF70, 16'h0000, 2'h3);
    check(rd, 16'h0000);
    $display("pull and unmapped done");
    tally_and_finish();
  end
endmodule // programmable_io_lines_tb
`default_nettype wire
